// file: charger_defs.svh
// command codes, status bit positions, mode bits and power-on values
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH

`define CMD_MODE_WORD        8'h12
`define CMD_STATE_WORD       8'h13
`define CMD_CURRENT_WORD     8'h14
`define CMD_VOLTAGE_WORD     8'h15
`define CMD_ALARM_WORD       8'h16

`define MODE_OFF_BIT         0
`define MODE_DEFAULTS_BIT    2
`define MODE_HOT_EN_BIT      10

`define ALARM_SET_MASK       16'hD000

`define ST_OFF               0
`define ST_MASTER            1
`define ST_V_UNREG           2
`define ST_I_UNREG           3
`define ST_TIER2             4
`define ST_TIER3             5
`define ST_I_OVER            6
`define ST_V_OVER            7
`define ST_T_OVER            8
`define ST_T_COLD            9
`define ST_PACK_HOT          10
`define ST_T_UNDER           11
`define ST_ALARM             12
`define ST_HEADROOM          13
`define ST_PACK_IN           14
`define ST_SUPPLY_OK         15

`define RST_CURRENT_WORD     16'h0007
`define RST_VOLTAGE_WORD     16'hFFFF
`define RST_OFF_FLAG         1'b0
`define RST_HOT_EN           1'b1
`define VOLT_LOW_LIMIT       16'h000F
`define CUR_STEP_SHIFT       7
`define CUR_TRICKLE_LIMIT    16'h007F
`define DAC_MAX_GND          5'h07
`define DAC_MAX_OPEN         5'h17
`define DAC_MAX_HIGH         5'h1F

`endif

// file: charger_pkg.sv
// types shared by the charger control logic
package charger_pkg;
    typedef enum logic [1:0] {
        RSEL_GND,
        RSEL_OPEN,
        RSEL_HIGH
    } range_sel_t;
endpackage

// file: sync_bus_if.sv
// carrier between the comparator synchroniser and the control logic
`timescale 1ns/1ps
`default_nettype none
interface sync_bus_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport ctrl (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

// file: input_sync.sv
// two-stage synchroniser bank for asynchronous comparator levels
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
    parameter int W = 1
) (
    input  wire logic clk_sys,  // system clock
    input  wire logic arst_n,   // async reset, active low
    sync_bus_if.sync  bus       // raw levels in, synced levels out
);
    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;
    logic [W-1:0] stage1_nxt;
    logic [W-1:0] stage2_nxt;

    if (W < 1) begin : g_chk
        $error("input_sync width must be at least one");
    end

    // first stage feeds only the second stage
    always_comb begin
        stage1_nxt = bus.raw;
        stage2_nxt = stage1_r;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
        end
    end

    assign bus.synced = stage2_r;
endmodule
`default_nettype wire

// file: charger_control_status_logic.sv
// command decode, current DAC mapping, latched flags and state word of the charger
`timescale 1ns/1ps
`default_nettype none
`include "charger_defs.svh"

module charger_control_status_logic
    import charger_pkg::*;
#(
    parameter logic [15:0] VOLT_MAX_WORD = 16'h47F0  // highest voltage word deliverable
) (
    input  wire logic        clk_sys,            // system clock, 250 MHz
    input  wire logic        arst_n,             // async reset, active low
    input  wire logic        cmd_wr,             // one-cycle write strobe
    input  wire logic [7:0]  cmd_code,           // command code of the write
    input  wire logic [15:0] cmd_data,           // data word of the write
    input  wire logic        voltage_loop_low,   // async comparator
    input  wire logic        voltage_unregulated,// async comparator
    input  wire logic        current_unregulated,// async comparator
    input  wire logic        therm_over,         // async comparator, sense above 91%
    input  wire logic        therm_cold,         // async comparator, sense above 75%
    input  wire logic        therm_hot,          // async comparator, sense below 23%
    input  wire logic        therm_under,        // async comparator, sense below 5%
    input  wire logic        headroom_low,       // async comparator
    input  wire logic        input_supply_ok,    // async comparator
    input  wire logic [1:0]  range_sel,          // strap: 0 ground, 1 open, 2/3 high
    output logic             trickle_output,     // trickle source enable
    output logic             regulator_on,       // low: high gate to switch node, low gate grounded
    output logic [4:0]       current_dac_code,   // regulator current code
    output logic [15:0]      charger_state_word  // state word for reads
);
    localparam int NSYNC = 11;

    if (VOLT_MAX_WORD <= `VOLT_LOW_LIMIT) begin : g_chk
        $error("voltage limit must lie above the lowest range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronised comparators
    sync_bus_if #(.W(NSYNC)) sbus ();

    assign sbus.raw = {range_sel, input_supply_ok, headroom_low, therm_under, therm_hot,
                       therm_cold, therm_over, current_unregulated, voltage_unregulated,
                       voltage_loop_low};

    input_sync #(.W(NSYNC)) u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .bus     (sbus)
    );

    logic       vll_s;
    logic       vun_s;
    logic       cun_s;
    logic       tover_s;
    logic       tcold_s;
    logic       thot_s;
    logic       tunder_s;
    logic       head_s;
    logic       supply_s;
    logic [1:0] rsel_raw_s;
    range_sel_t rsel;

    assign {rsel_raw_s, supply_s, head_s, tunder_s, thot_s, tcold_s, tover_s,
            cun_s, vun_s, vll_s} = sbus.synced;
    assign rsel = (rsel_raw_s == 2'h0) ? RSEL_GND :
                  (rsel_raw_s == 2'h1) ? RSEL_OPEN : RSEL_HIGH;

    ////////////////////////////////////////////////////////////////////////////
    // setpoints, mode and latches
    logic [15:0] volt_r, volt_nxt;
    logic [15:0] cur_r, cur_nxt;
    logic        off_r, off_nxt;
    logic        hot_en_r, hot_en_nxt;
    logic        hot_r, hot_nxt;
    logic        alarm_r, alarm_nxt;

    logic pack_in;
    logic wr_mode;
    logic wr_cur;
    logic wr_volt;
    logic wr_alarm;
    logic defaults;

    assign pack_in  = ~tover_s;
    assign wr_mode  = cmd_wr && (cmd_code == `CMD_MODE_WORD);
    assign wr_cur   = cmd_wr && (cmd_code == `CMD_CURRENT_WORD);
    assign wr_volt  = cmd_wr && (cmd_code == `CMD_VOLTAGE_WORD);
    assign wr_alarm = cmd_wr && (cmd_code == `CMD_ALARM_WORD);
    assign defaults = wr_mode && cmd_data[`MODE_DEFAULTS_BIT];

    always_comb begin
        volt_nxt   = volt_r;
        cur_nxt    = cur_r;
        off_nxt    = off_r;
        hot_en_nxt = hot_en_r;
        hot_nxt    = hot_r;
        alarm_nxt  = alarm_r;
        if (wr_mode) begin
            off_nxt    = cmd_data[`MODE_OFF_BIT];
            hot_en_nxt = cmd_data[`MODE_HOT_EN_BIT];
        end
        if (wr_volt) begin
            volt_nxt = cmd_data;
        end
        if (wr_cur) begin
            cur_nxt = cmd_data;
        end
        if (defaults) begin
            volt_nxt = `RST_VOLTAGE_WORD;
            cur_nxt  = `RST_CURRENT_WORD;
        end
        // removal wins over a current write so insertion restarts at trickle
        if (!pack_in) begin
            cur_nxt = `RST_CURRENT_WORD;
        end
        if (!pack_in || defaults) begin
            hot_nxt = 1'b0;
        end
        if (!pack_in || defaults || wr_volt || wr_cur) begin
            alarm_nxt = 1'b0;
        end
        // a set arriving with a clear is not lost
        if (thot_s) begin
            hot_nxt = 1'b1;
        end
        if (wr_alarm && |(cmd_data & `ALARM_SET_MASK)) begin
            alarm_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            volt_r   <= `RST_VOLTAGE_WORD;
            cur_r    <= `RST_CURRENT_WORD;
            off_r    <= `RST_OFF_FLAG;
            hot_en_r <= `RST_HOT_EN;
            hot_r    <= 1'b0;
            alarm_r  <= 1'b0;
        end else begin
            volt_r   <= volt_nxt;
            cur_r    <= cur_nxt;
            off_r    <= off_nxt;
            hot_en_r <= hot_en_nxt;
            hot_r    <= hot_nxt;
            alarm_r  <= alarm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // current mapping and source enables
    logic       hot_shutdown_enable;
    logic       blocked;
    logic       volt_low;
    logic [8:0] steps;
    logic [4:0] dac_max;
    logic       cur_over;
    logic [4:0] dac_clamped;

    assign hot_shutdown_enable = hot_r && hot_en_r && !tunder_s;
    assign blocked  = off_r || hot_shutdown_enable || alarm_r;
    assign volt_low = (volt_r <= `VOLT_LOW_LIMIT);
    assign steps    = cur_r[15:`CUR_STEP_SHIFT];

    always_comb begin
        unique case (rsel)
            RSEL_GND:  dac_max = `DAC_MAX_GND;
            RSEL_OPEN: dac_max = `DAC_MAX_OPEN;
            RSEL_HIGH: dac_max = `DAC_MAX_HIGH;
        endcase
    end

    assign cur_over    = !volt_low && (steps > {4'h0, dac_max});
    assign dac_clamped = cur_over ? dac_max : steps[4:0];

    logic       trickle_r, trickle_nxt;
    logic       reg_on_r, reg_on_nxt;
    logic [4:0] dac_r, dac_nxt;
    logic [15:0] state_r, state_nxt;

    always_comb begin
        trickle_nxt = 1'b0;
        reg_on_nxt  = 1'b0;
        dac_nxt     = 5'h00;
        // stopped or lowest voltage: both sources off
        if (!blocked && !volt_low) begin
            if (cur_r <= `CUR_TRICKLE_LIMIT) begin
                // regulator stays off below first step
                trickle_nxt = (cur_r != 16'h0000) && !(vll_s && !vun_s);
            end else begin
                dac_nxt    = dac_clamped;
                reg_on_nxt = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state word
    always_comb begin
        state_nxt                = 16'h0000;
        state_nxt[`ST_OFF]       = off_r;
        state_nxt[`ST_MASTER]    = 1'b0;
        state_nxt[`ST_V_UNREG]   = vun_s;
        state_nxt[`ST_I_UNREG]   = cun_s;
        state_nxt[`ST_TIER2]     = 1'b1;
        state_nxt[`ST_TIER3]     = 1'b0;
        state_nxt[`ST_I_OVER]    = cur_over;
        state_nxt[`ST_V_OVER]    = (volt_r > VOLT_MAX_WORD);
        state_nxt[`ST_T_OVER]    = tover_s;
        state_nxt[`ST_T_COLD]    = tcold_s;
        state_nxt[`ST_PACK_HOT]  = hot_r;
        state_nxt[`ST_T_UNDER]   = tunder_s;
        state_nxt[`ST_ALARM]     = alarm_r;
        state_nxt[`ST_HEADROOM]  = head_s;
        state_nxt[`ST_PACK_IN]   = pack_in;
        state_nxt[`ST_SUPPLY_OK] = supply_s;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trickle_r <= 1'b0;
            reg_on_r  <= 1'b0;
            dac_r     <= 5'h00;
            state_r   <= 16'h0000;
        end else begin
            trickle_r <= trickle_nxt;
            reg_on_r  <= reg_on_nxt;
            dac_r     <= dac_nxt;
            state_r   <= state_nxt;
        end
    end

    // low byte is shifted out first by the serial front end
    assign trickle_output     = trickle_r;
    assign regulator_on       = reg_on_r;
    assign current_dac_code   = dac_r;
    assign charger_state_word = state_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // hot latch, enable and no underrange seen together must have stopped both sources
    chk_hot_term: assert property (charger_state_word[`ST_PACK_HOT] && $past(hot_en_r)
                                   && !charger_state_word[`ST_T_UNDER]
                                   |-> !trickle_output && !regulator_on)
        else $error("hot shutdown term wrong");
    chk_stop_all: assert property (blocked |=> !trickle_output && !regulator_on)
        else $error("sources not off while stopped");
    chk_low_volt: assert property (volt_low |=> !trickle_output && !regulator_on
                                   && !charger_state_word[`ST_I_OVER])
        else $error("lowest voltage word did not stop sources");
    chk_below_step: assert property (cur_r <= `CUR_TRICKLE_LIMIT
                                     |=> current_dac_code == 5'h00 && !regulator_on)
        else $error("code not zero below first step");
    chk_trickle_on: assert property (!blocked && !volt_low && cur_r != 16'h0000
                                     && cur_r <= `CUR_TRICKLE_LIMIT && !vll_s
                                     |=> trickle_output)
        else $error("trickle not enabled");
    chk_trickle_excl: assert property (regulator_on |-> !trickle_output
                                       && current_dac_code != 5'h00)
        else $error("trickle on with regulator");
    chk_clamp_gnd: assert property (!blocked && !volt_low && rsel == RSEL_GND
                                    && cur_r >= 16'h0400
                                    |=> current_dac_code == 5'h07
                                        && charger_state_word[`ST_I_OVER])
        else $error("ground clamp wrong");
    chk_clamp_open: assert property (!blocked && !volt_low && rsel == RSEL_OPEN
                                     && cur_r >= 16'h0C00
                                     |=> current_dac_code == 5'h17
                                         && charger_state_word[`ST_I_OVER])
        else $error("open clamp wrong");
    chk_sat_high: assert property (!blocked && !volt_low && rsel == RSEL_HIGH
                                   && cur_r >= 16'h0F80 && cur_r <= 16'h0FFF
                                   |=> current_dac_code == 5'h1F
                                       && !charger_state_word[`ST_I_OVER])
        else $error("high select saturation wrong");
    chk_alarm_set: assert property (wr_alarm && |(cmd_data & 16'hD000)
                                    |=> ##1 charger_state_word[`ST_ALARM])
        else $error("alarm lockout not set");
    chk_alarm_clr: assert property ((wr_volt || wr_cur) && !wr_alarm |=> !alarm_r)
        else $error("lockout not cleared by setpoint");
    chk_hot_latch: assert property (thot_s |=> hot_r ##1 charger_state_word[`ST_PACK_HOT])
        else $error("hot latch not set");
    // state word is still all zero at the first edge after release
    chk_fixed_bits: assert property ($past(arst_n) |-> charger_state_word[5:4] == 2'b01
                                     && !charger_state_word[`ST_MASTER])
        else $error("fixed state bits wrong");
    chk_pack_in: assert property ($past(arst_n) |-> charger_state_word[`ST_PACK_IN]
                                  == ~charger_state_word[`ST_T_OVER])
        else $error("pack present not inverse of overrange");
    chk_cur_restore: assert property (!pack_in |=> cur_r == 16'h0007)
        else $error("current word not restored");
    chk_live_loops: assert property (##1 charger_state_word[3:2] == $past({cun_s, vun_s}))
        else $error("loop bits not live");

    cov_trickle:  cover property (trickle_output ##1 regulator_on);
    cov_alarm:    cover property (wr_alarm ##2 alarm_r ##[1:20] wr_cur);
    cov_hot_shutdown_enable: cover property (hot_shutdown_enable && regulator_on);
    cov_removal:  cover property (!pack_in && alarm_r);
endmodule
`default_nettype wire

// file: host_model.sv
// host side model: writes command words and reads the state word
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clk_sys,   // system clock
    output var  logic        cmd_wr,    // write strobe
    output var  logic [7:0]  cmd_code,  // command code
    output var  logic [15:0] cmd_data,  // data word
    input  wire logic [15:0] state_word // state word from the device
);
    initial begin
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        cmd_data = 16'h0000;
    end
    // one word per call, strobe dropped after the taking edge
    task automatic write_word(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk_sys);
        #1;
        cmd_wr = 1'b1;
        cmd_code = code;
        cmd_data = data;
        @(posedge clk_sys);
        #1;
        cmd_wr = 1'b0;
        // released lines must not keep looking valid
        cmd_code = ~code;
        cmd_data = ~data;
    endtask
    task automatic read_word(output logic [15:0] w);
        logic [7:0] lo;
        logic [7:0] hi;
        @(posedge clk_sys);
        #1;
        lo = state_word[7:0];
        hi = state_word[15:8];
        w = {hi, lo};
    endtask
endmodule
`default_nettype wire

// file: test_charger_control_status_logic.sv
// self-checking bench of the charger control and state logic
`timescale 1ns/1ps
`default_nettype none
`include "charger_defs.svh"
module test_charger_control_status_logic;
    localparam logic [15:0] VMAX = 16'h47F0;
    logic        clk_sys, arst_n, vll, vun, cun, tov, tcold, thot, tun, hdr, sok;
    logic [1:0]  rsel;
    logic        cmd_wr, trickle_output, regulator_on;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_data, charger_state_word, volt, cur, d;
    logic [4:0]  current_dac_code;
    logic        off_f, hot_en, hot_l, alm_l;
    logic [31:0] q;
    logic [7:0]  c;
    logic [15:0] corner [12] = '{16'h007F, 16'h0080, 16'h037F, 16'h0380, 16'h03FF, 16'h0400,
                                 16'h0B80, 16'h0BFF, 16'h0C00, 16'h0F80, 16'h1000, 16'hFFFF};
    logic [7:0]  codes [8] = '{8'h12, 8'h14, 8'h14, 8'h15, 8'h15, 8'h16, 8'h13, 8'h40};
    integer      seed, err_count, n_tests, i, r;

    charger_control_status_logic #(.VOLT_MAX_WORD(VMAX)) u_charger_control_status_logic (
        .clk_sys(clk_sys), .arst_n(arst_n), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .voltage_loop_low(vll), .voltage_unregulated(vun),
        .current_unregulated(cun), .therm_over(tov), .therm_cold(tcold), .therm_hot(thot),
        .therm_under(tun), .headroom_low(hdr), .input_supply_ok(sok), .range_sel(rsel),
        .trickle_output(trickle_output), .regulator_on(regulator_on),
        .current_dac_code(current_dac_code), .charger_state_word(charger_state_word));
    host_model u_host_model (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .state_word(charger_state_word));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_word();
        logic io;
        io = (volt > 16'h000F) && ((rsel == 2'd0) ? cur >= 16'h0400 :
             (rsel == 2'd1) ? cur >= 16'h0C00 : cur >= 16'h1000);
        return {sok, ~tov, hdr, alm_l, tun, hot_l, tcold, tov, volt > VMAX, io,
                2'b01, cun, vun, 1'b0, off_f};
    endfunction
    function automatic logic [6:0] exp_out();
        logic       stop;
        logic [4:0] mx;
        logic [4:0] k;
        stop = off_f | (hot_l & hot_en & ~tun) | alm_l | (volt <= 16'h000F);
        mx = (rsel == 2'd0) ? 5'h07 : (rsel == 2'd1) ? 5'h17 : 5'h1F;
        k = (cur >= 16'h1000) ? 5'h1F : cur[11:7];
        if (k > mx) k = mx;
        if (stop) k = 5'h00;
        return {!stop && cur != 16'h0000 && cur <= 16'h007F && !(vll && !vun), k != 5'h00, k};
    endfunction
    // removal clears latches every cycle, hot comparator wins
    function automatic void settle();
        if (thot) hot_l = 1'b1;
        else if (tov) hot_l = 1'b0;
        if (tov) alm_l = 1'b0;
        if (tov) cur = 16'h0007;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic verify();
        logic [15:0] w;
        repeat (4) @(posedge clk_sys);
        #1;
        check({9'h000, trickle_output, regulator_on, current_dac_code}, {9'h000, exp_out()},
              "outputs");
        u_host_model.read_word(w);
        check(w, exp_word(), "state word");
    endtask
    task automatic set_pins(input logic [10:0] p);
        logic [15:0] w0;
        @(posedge clk_sys);
        #1;
        w0 = charger_state_word;
        {rsel, vll, vun, cun, tov, tcold, thot, tun, hdr, sok} = p;
        repeat (2) @(posedge clk_sys);
        #1;
        check(charger_state_word, w0, "early pin");
        repeat (2) @(posedge clk_sys);
        settle();
    endtask
    task automatic wr(input logic [7:0] cc, input logic [15:0] dd);
        u_host_model.write_word(cc, dd);
        case (cc)
            `CMD_MODE_WORD: begin
                off_f = dd[0];
                hot_en = dd[10];
                if (dd[2]) begin
                    volt = 16'hFFFF;
                    cur = 16'h0007;
                    hot_l = 1'b0;
                    alm_l = 1'b0;
                end
            end
            `CMD_CURRENT_WORD, `CMD_VOLTAGE_WORD: begin
                if (cc == `CMD_CURRENT_WORD) cur = dd;
                else volt = dd;
                alm_l = 1'b0;
            end
            `CMD_ALARM_WORD: if ((dd & 16'hD000) != 16'h0000) alm_l = 1'b1;
            default: ;
        endcase
        settle();
    endtask
    task automatic do_reset();
        arst_n = 1'b0;
        {off_f, hot_en, hot_l, alm_l} = 4'b0100;
        volt = 16'hFFFF;
        cur = 16'h0007;
        repeat (12) @(posedge clk_sys);
        #1;
        check({9'h000, trickle_output, regulator_on, current_dac_code}, 16'h0000,
              "outputs in reset");
        check(charger_state_word, 16'h0000, "state in reset");
        arst_n = 1'b1;
        settle();
        verify();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 94424;
        err_count = 0;
        n_tests = 0;
        {rsel, vll, vun, cun, tov, tcold, thot, tun, hdr, sok} = 11'h001;
        do_reset();
        wr(`CMD_VOLTAGE_WORD, 16'h4000);
        for (r = 0; r < 4; r++) begin
            set_pins({r[1:0], 9'h001});
            for (i = 0; i < 12; i++) begin
                wr(`CMD_CURRENT_WORD, corner[i]);
                verify();
            end
        end
        set_pins(11'h001);
        foreach (corner[i]) begin
            wr(`CMD_VOLTAGE_WORD, {12'h000, i[3:0]} + 16'h0008 + (i > 8 ? 16'h47E0 : 16'h0));
            wr(`CMD_CURRENT_WORD, 16'h0405);
            verify();
        end
        for (i = 0; i < 16; i++) begin
            wr(`CMD_ALARM_WORD, 16'h0001 << i);
            verify();
            wr(i[0] ? `CMD_CURRENT_WORD : `CMD_VOLTAGE_WORD, 16'h0203);
            verify();
        end
        set_pins(11'h009);
        verify();
        wr(`CMD_MODE_WORD, 16'h0404);
        verify();
        for (i = 0; i < 300; i++) begin
            q = $random(seed);
            set_pins({q[10:9], q[0], q[1], q[2], q[3] & q[4] & q[5], q[6], q[7] & q[8],
                      q[11] & q[15], q[12], q[13]});
            q = $random(seed);
            c = codes[q[22:20]];
            d = q[31:16] >> q[3:0];
            if (c == `CMD_MODE_WORD) d[0] = d[0] & q[5] & q[6];
            wr(c, d);
            verify();
        end
        do_reset();
        summarize();
    end
    // a hang counts as a mismatch and ends the run the normal way
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
